// ### verification/cal_calendar_clock_tb.sv
`timescale 1ns/10ps
`include "cal_defs.svh"

module cal_calendar_clock_tb
    import cal_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xtalClk = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic weI = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] datI = 32'h00000000;
    logic [31:0] datO;
    logic ackO;
    logic calendarPin;
    int errTotal = 0;
    int comparisons = 0;
    logic [7:0] yr [4] = '{8'h00, 8'h01, 8'h00, 8'h99};
    logic [15:0] md [4] = '{16'h0228, 16'h0228, 16'h0229, 16'h1231};
    logic [7:0] eyr [4] = '{8'h00, 8'h01, 8'h00, 8'h00};
    logic [15:0] emd [4] = '{16'h0229, 16'h0301, 16'h0301, 16'h0101};

    // A small crystal count keeps one second at eight ticks.
    cal_calendar_clock #(.XTAL_HZ(8)) cal_calendar_clock_inst (
        .clk(clk), .rst_n(rst_n), .xtalClk(xtalClk), .cyc_i(cyc), .stb_i(stb), .we_i(weI),
        .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ackO), .calendarPin(calendarPin)
    );

    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request stands until the edge that samples ack high; read data is taken at that same edge.
    task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [15:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        weI <= w;
        adr <= a;
        sel <= s;
        datI <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ackO !== 1'b1 && n < 50);
        chk({31'h00000000, ackO}, 32'h00000001);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        weI <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [3:0] s, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, s, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 4'h3, 16'h0000, q);
        chk(q, {16'h0000, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            xtalClk <= 1'b1;
            repeat (3) @(posedge clk);
            xtalClk <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic test_lock;
        rd(`CAL_OFS_CONFIG, 16'h0000);
        chk({31'h0, calendarPin}, 32'h00000000);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h0300);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h1234);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h0300);
        rd(`CAL_OFS_VALUE_WIN, 16'h0000);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h1234);
        rd(`CAL_OFS_VALUE_WIN, 16'h0000);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h8000);
        rd(`CAL_OFS_CONFIG, 16'h0000);
        wr(`CAL_OFS_UNLOCK_KEY, 4'h1, 16'h0055);
        wr(`CAL_OFS_UNLOCK_KEY, 4'h1, 16'h00AA);
        rd(`CAL_OFS_UNLOCK_KEY, 16'h0000);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2000);
        rd(`CAL_OFS_CONFIG, 16'h0000);
        wr(`CAL_OFS_UNLOCK_KEY, 4'h1, 16'h0055);
        wr(`CAL_OFS_UNLOCK_KEY, 4'h1, 16'h00AA);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2000);
        rd(`CAL_OFS_CONFIG, 16'h2000);
        $display("test lock done");
    endtask

    task automatic test_value_window;
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2300);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'hFF99);
        rd(`CAL_OFS_CONFIG, 16'h2200);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h1231);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h0623);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h5958);
        rd(`CAL_OFS_CONFIG, 16'h2000);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2300);
        rd(`CAL_OFS_VALUE_WIN, 16'h0099);
        rd(`CAL_OFS_VALUE_WIN, 16'h1231);
        rd(`CAL_OFS_VALUE_WIN, 16'h0623);
        rd(`CAL_OFS_VALUE_WIN, 16'h5958);
        rd(`CAL_OFS_VALUE_WIN, 16'h5958);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2200);
        wr(`CAL_OFS_VALUE_WIN, 4'h1, 16'h0030);
        rd(`CAL_OFS_CONFIG, 16'h2200);
        $display("test value window done");
    endtask

    task automatic test_alarm_window;
        wr(`CAL_OFS_ALARM_CFG, 4'h3, 16'h0200);
        wr(`CAL_OFS_ALARM_WIN, 4'h3, 16'h0101);
        wr(`CAL_OFS_ALARM_WIN, 4'h3, 16'h0000);
        wr(`CAL_OFS_ALARM_WIN, 4'h3, 16'h0001);
        rd(`CAL_OFS_ALARM_CFG, 16'h0000);
        wr(`CAL_OFS_ALARM_CFG, 4'h3, 16'h0300);
        rd(`CAL_OFS_ALARM_WIN, 16'h0000);
        rd(`CAL_OFS_ALARM_WIN, 16'h0101);
        rd(`CAL_OFS_ALARM_WIN, 16'h0000);
        rd(`CAL_OFS_ALARM_WIN, 16'h0001);
        rd(`CAL_OFS_ALARM_WIN, 16'h0001);
        wr(`CAL_OFS_ALARM_CFG, 4'h3, 16'h0200);
        wr(`CAL_OFS_ALARM_WIN, 4'h1, 16'h0001);
        rd(`CAL_OFS_ALARM_CFG, 16'h0200);
        wr(`CAL_OFS_ALARM_CFG, 4'h3, 16'h0000);
        $display("test alarm window done");
    endtask

    // Each case starts one second before midnight so the carry runs through seconds, minutes, hours and day, and on into month and year where they end.
    task automatic test_rollover;
        for (int i = 0; i < 4; i++) begin
            wr(`CAL_OFS_CONFIG, 4'h3, 16'h2300);
            wr(`CAL_OFS_VALUE_WIN, 4'h3, {8'h00, yr[i]});
            wr(`CAL_OFS_VALUE_WIN, 4'h3, md[i]);
            wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h0623);
            wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h5959);
            wr(`CAL_OFS_CONFIG, 4'h3, 16'hA000);
            tick(8);
            wr(`CAL_OFS_CONFIG, 4'h3, 16'h2300);
            rd(`CAL_OFS_VALUE_WIN, {8'h00, eyr[i]});
            rd(`CAL_OFS_VALUE_WIN, emd[i]);
            rd(`CAL_OFS_VALUE_WIN, 16'h0000);
            rd(`CAL_OFS_VALUE_WIN, 16'h0000);
        end
        $display("test rollover done");
    endtask

    task automatic test_half_second;
        wr(`CAL_OFS_CONFIG, 4'h3, 16'hA000);
        tick(4);
        rd(`CAL_OFS_CONFIG, 16'hA800);
        wr(`CAL_OFS_VALUE_WIN, 4'h1, 16'h0000);
        rd(`CAL_OFS_CONFIG, 16'hA000);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2000);
        $display("test half second done");
    endtask

    task automatic test_alarm_pin;
        wr(`CAL_OFS_PAD_CFG, 4'h3, 16'h0000);
        rd(`CAL_OFS_PAD_CFG, 16'h0000);
        wr(`CAL_OFS_ALARM_CFG, 4'h3, 16'h8000);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'hA400);
        chk({31'h0, calendarPin}, 32'h00000000);
        tick(8);
        chk({31'h0, calendarPin}, 32'h00000001);
        rd(`CAL_OFS_ALARM_CFG, 16'h0000);
        wr(`CAL_OFS_PAD_CFG, 4'h3, 16'h0002);
        rd(`CAL_OFS_PAD_CFG, 16'h0002);
        chk({31'h0, calendarPin}, 32'h00000001);
        $display("test alarm pin done");
    endtask

    // Code FF swallows four ticks after the minute rolls, so the next second needs twelve ticks.
    task automatic test_calibration;
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h2000);
        wr(`CAL_OFS_VALUE_WIN, 4'h3, 16'h0059);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'hA0FF);
        tick(19);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h20FF);
        rd(`CAL_OFS_VALUE_WIN, 16'h0100);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'hA0FF);
        tick(1);
        wr(`CAL_OFS_CONFIG, 4'h3, 16'h0000);
        rd(`CAL_OFS_VALUE_WIN, 16'h0101);
        rd(`CAL_OFS_CONFIG, 16'h0000);
        $display("test calibration done");
    endtask

    task automatic printVerdict;
        $display("comparisons=%0d mismatches=%0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_lock();
        test_value_window();
        test_alarm_window();
        test_rollover();
        test_half_second();
        test_alarm_pin();
        test_calibration();
        printVerdict();
    end

    // The whole sequence needs well under ten thousand cycles.
    initial begin
        #(25 * 40000);
        errTotal++;
        printVerdict();
    end
endmodule // cal_calendar_clock_tb

// ### verilog/cal_calendar_clock.sv
// Contract
// - Calendar runs from 2000 through 2099.
// - Hours shown only in 24-hour form.
// - One-second counting, half-second status visible.
// - Leap years lengthen February automatically.
// - All time fields held in BCD.
// - Time counted from 32.768 kHz crystal.
// - Pin shows alarm pulse or seconds clock.
// - Calibration corrects to within 2.64 s/month.
// - Config bits 9:8 select value window pair.
// - Pointer maps min/sec, wday/hour, month/day, year.
// - High-byte write decrements value pointer, saturating.
// - At zero window stays on minutes/seconds.
// - Alarm config bits 9:8 select alarm pair.
// - Alarm pointer maps three pairs, 11 unimplemented.
// - Alarm high write decrements pointer, saturating.
// - Any alarm window read decrements alarm pointer.
// - Any value window read decrements value pointer.
// - Low-byte writes leave pointers unchanged.
// - Time writes need write-unlock bit 13 set.
// - Unlock bit settable only right after 55h/AAh.
// - Calibration adds or subtracts 4n pulses per minute.
// - Enable bit writable only while unlocked.
// - Seconds write clears half-second status.
`timescale 1ns/10ps
`include "cal_defs.svh"

module cal_calendar_clock
    import cal_pkg::*;
#(
    parameter int unsigned XTAL_HZ = `CAL_XTAL_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic xtalClk,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic calendarPin
);

    localparam logic [14:0] LAST_TICK = 15'(XTAL_HZ - 1);
    localparam logic [14:0] HALF_TICK = 15'(XTAL_HZ / 2);
    localparam cal_state_t RESET_STATE = '{
        now: '{sec: 8'h00, min: 8'h00, hour: 8'h00, wday: 8'h00,
               day: `CAL_RST_DAY, month: `CAL_RST_MONTH, year: `CAL_RST_YEAR},
        alarm: '{sec: 8'h00, min: 8'h00, hour: 8'h00, wday: 8'h00,
                 day: `CAL_RST_DAY, month: `CAL_RST_MONTH, year: 8'h00},
        valuePtr: 2'h0, alarmPtr: 2'h0, calib: 8'h00,
        enable: 1'b0, unlock: 1'b0, outEnable: 1'b0, outSelect: 1'b0,
        alarmEnable: 1'b0, alarmPulse: 1'b0, pinOut: 1'b0, xtalPrev: 1'b0,
        ack: 1'b0, prescaler: 15'h0000, swallow: 10'h000,
        keyState: KEY_IDLE, rdData: 16'h0000
    };

    cal_state_t s;
    cal_state_t next_s;
    logic xtalEdge;
    logic halfSecond;
    logic request;
    logic [4:0] wordAdr;
    logic [7:0] negMag;

    // Increment a BCD byte; callers handle the field's own wrap.
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Last day of a month in BCD; every year divisible by four is a leap year.
    function automatic logic [7:0] lastDay(input logic [7:0] month, input logic [7:0] year);
        logic [6:0] yearBin;
        yearBin = 7'(year[7:4]) * 7'hA + 7'(year[3:0]);
        unique case (month)
            8'h02: lastDay = (yearBin[1:0] == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
            default: lastDay = 8'h31;
        endcase
    endfunction

    function automatic logic [15:0] valueWin(input cal_time_t t, input logic [1:0] ptr);
        unique case (ptr)
            2'h0: valueWin = {t.min, t.sec};
            2'h1: valueWin = {t.wday, t.hour};
            2'h2: valueWin = {t.month, t.day};
            2'h3: valueWin = {8'h00, t.year};
        endcase
    endfunction

    function automatic logic [15:0] alarmWin(input cal_time_t t, input logic [1:0] ptr);
        unique case (ptr)
            2'h0: alarmWin = {t.min, t.sec};
            2'h1: alarmWin = {t.wday, t.hour};
            2'h2: alarmWin = {t.month, t.day};
            2'h3: alarmWin = 16'h0000;
        endcase
    endfunction

    function automatic logic [1:0] ptrDec(input logic [1:0] ptr);
        return (ptr == 2'h0) ? 2'h0 : ptr - 2'h1;
    endfunction

    // The crystal is sampled as a plain synchronous input; each rising edge is one tick.
    assign xtalEdge = xtalClk & ~s.xtalPrev;
    assign halfSecond = (s.prescaler >= HALF_TICK);
    assign request = cyc_i & stb_i & ~s.ack;
    assign wordAdr = {adr_i[4:2], 2'b00};
    assign negMag = 8'h00 - s.calib;
    assign dat_o = {16'h0000, s.rdData};
    assign ack_o = s.ack;
    assign calendarPin = s.pinOut;

    always_comb begin
        next_s = s;
        next_s.xtalPrev = xtalClk;
        next_s.ack = 1'b0;

        if (s.enable && xtalEdge) begin
            if (s.swallow != 10'h000) begin
                next_s.swallow = s.swallow - 10'h001;
            end else if (s.prescaler != LAST_TICK) begin
                next_s.prescaler = s.prescaler + 15'h0001;
            end else begin
                next_s.prescaler = 15'h0000;
                next_s.now.sec = bcdInc(s.now.sec);
                if (s.now.sec == 8'h59) begin
                    next_s.now.sec = 8'h00;
                    // Once a minute the calibration either skips ahead or swallows ticks.
                    if (s.calib[7]) begin
                        next_s.swallow = {negMag, 2'b00};
                    end else begin
                        next_s.prescaler = 15'({s.calib[6:0], 2'b00});
                    end
                    next_s.now.min = bcdInc(s.now.min);
                    if (s.now.min == 8'h59) begin
                        next_s.now.min = 8'h00;
                        next_s.now.hour = bcdInc(s.now.hour);
                        if (s.now.hour == 8'h23) begin
                            next_s.now.hour = 8'h00;
                            next_s.now.wday = (s.now.wday == 8'h06) ? 8'h00 : bcdInc(s.now.wday);
                            next_s.now.day = bcdInc(s.now.day);
                            if (s.now.day == lastDay(s.now.month, s.now.year)) begin
                                next_s.now.day = 8'h01;
                                next_s.now.month = bcdInc(s.now.month);
                                if (s.now.month == 8'h12) begin
                                    next_s.now.month = 8'h01;
                                    next_s.now.year = (s.now.year == 8'h99) ? 8'h00 : bcdInc(s.now.year);
                                end
                            end
                        end
                    end
                end
                next_s.alarmPulse = 1'b0;
                if (s.alarmEnable && next_s.now.sec == s.alarm.sec && next_s.now.min == s.alarm.min
                    && next_s.now.hour == s.alarm.hour && next_s.now.wday == s.alarm.wday
                    && next_s.now.day == s.alarm.day && next_s.now.month == s.alarm.month) begin
                    next_s.alarmPulse = 1'b1;
                    next_s.alarmEnable = 1'b0;
                end
            end
        end

        if (request) begin
            next_s.ack = 1'b1;
            next_s.rdData = 16'h0000;
            // The key stays open for exactly one following bus access.
            if (!(we_i && wordAdr == `CAL_OFS_UNLOCK_KEY)) begin
                next_s.keyState = KEY_IDLE;
            end
            unique case (wordAdr)
                `CAL_OFS_CONFIG: begin
                    next_s.rdData = {s.enable, 1'b0, s.unlock, 1'b0, halfSecond, s.outEnable,
                                     s.valuePtr, s.calib};
                    if (we_i && sel_i[1]) begin
                        next_s.valuePtr = dat_i[`CAL_PTR_HI:`CAL_PTR_LO];
                        next_s.outEnable = dat_i[`CAL_BIT_OUTEN];
                        if (!dat_i[`CAL_BIT_UNLOCK]) begin
                            next_s.unlock = 1'b0;
                        end else if (s.keyState == KEY_OPEN) begin
                            next_s.unlock = 1'b1;
                        end
                        if (s.unlock) begin
                            next_s.enable = dat_i[`CAL_BIT_ENABLE];
                        end
                    end
                    if (we_i && sel_i[0]) begin
                        next_s.calib = dat_i[7:0];
                    end
                end
                `CAL_OFS_VALUE_WIN: begin
                    if (!we_i) begin
                        next_s.rdData = valueWin(s.now, s.valuePtr);
                        next_s.valuePtr = ptrDec(s.valuePtr);
                    end else begin
                        if (s.unlock) begin
                            if (sel_i[1]) begin
                                unique case (s.valuePtr)
                                    2'h0: next_s.now.min = dat_i[15:8];
                                    2'h1: next_s.now.wday = dat_i[15:8];
                                    2'h2: next_s.now.month = dat_i[15:8];
                                    2'h3: ;
                                endcase
                            end
                            if (sel_i[0]) begin
                                unique case (s.valuePtr)
                                    2'h0: begin
                                        next_s.now.sec = dat_i[7:0];
                                        next_s.prescaler = 15'h0000;
                                        next_s.swallow = 10'h000;
                                    end
                                    2'h1: next_s.now.hour = dat_i[7:0];
                                    2'h2: next_s.now.day = dat_i[7:0];
                                    2'h3: next_s.now.year = dat_i[7:0];
                                endcase
                            end
                        end
                        if (sel_i[1]) begin
                            next_s.valuePtr = ptrDec(s.valuePtr);
                        end
                    end
                end
                `CAL_OFS_ALARM_CFG: begin
                    next_s.rdData = {s.alarmEnable, 5'h00, s.alarmPtr, 8'h00};
                    if (we_i && sel_i[1]) begin
                        next_s.alarmEnable = dat_i[`CAL_BIT_ALARM_EN];
                        next_s.alarmPtr = dat_i[`CAL_PTR_HI:`CAL_PTR_LO];
                    end
                end
                `CAL_OFS_ALARM_WIN: begin
                    if (!we_i) begin
                        next_s.rdData = alarmWin(s.alarm, s.alarmPtr);
                        next_s.alarmPtr = ptrDec(s.alarmPtr);
                    end else begin
                        if (sel_i[1]) begin
                            unique case (s.alarmPtr)
                                2'h0: next_s.alarm.min = dat_i[15:8];
                                2'h1: next_s.alarm.wday = dat_i[15:8];
                                2'h2: next_s.alarm.month = dat_i[15:8];
                                2'h3: ;
                            endcase
                            next_s.alarmPtr = ptrDec(s.alarmPtr);
                        end
                        if (sel_i[0]) begin
                            unique case (s.alarmPtr)
                                2'h0: next_s.alarm.sec = dat_i[7:0];
                                2'h1: next_s.alarm.hour = dat_i[7:0];
                                2'h2: next_s.alarm.day = dat_i[7:0];
                                2'h3: ;
                            endcase
                        end
                    end
                end
                `CAL_OFS_UNLOCK_KEY: begin
                    if (we_i) begin
                        unique case (s.keyState)
                            KEY_IDLE, KEY_OPEN: begin
                                next_s.keyState = (dat_i[7:0] == `CAL_KEY_FIRST) ? KEY_SAW_FIRST : KEY_IDLE;
                            end
                            KEY_SAW_FIRST: begin
                                next_s.keyState = (dat_i[7:0] == `CAL_KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
                            end
                        endcase
                    end
                end
                `CAL_OFS_PAD_CFG: begin
                    next_s.rdData = {14'h0000, s.outSelect, 1'b0};
                    if (we_i && sel_i[0]) begin
                        next_s.outSelect = dat_i[`CAL_BIT_OUT_SELECT];
                    end
                end
                default: ;
            endcase
        end

        // The seconds clock is high in the first half of each second.
        next_s.pinOut = s.outEnable & (s.outSelect ? ~halfSecond : s.alarmPulse);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic valueRd;
    logic valueHiWr;
    logic valueLoOnlyWr;
    logic alarmRd;
    logic cfgHiWr;
    logic alarmHiWr;
    logic alarmLoOnlyWr;
    logic alarmCfgHiWr;
    assign valueRd = request && !we_i && wordAdr == `CAL_OFS_VALUE_WIN;
    assign valueHiWr = request && we_i && sel_i[1] && wordAdr == `CAL_OFS_VALUE_WIN;
    assign valueLoOnlyWr = request && we_i && !sel_i[1] && wordAdr == `CAL_OFS_VALUE_WIN;
    assign alarmRd = request && !we_i && wordAdr == `CAL_OFS_ALARM_WIN;
    assign cfgHiWr = request && we_i && sel_i[1] && wordAdr == `CAL_OFS_CONFIG;
    assign alarmHiWr = request && we_i && sel_i[1] && wordAdr == `CAL_OFS_ALARM_WIN;
    assign alarmLoOnlyWr = request && we_i && !sel_i[1] && wordAdr == `CAL_OFS_ALARM_WIN;
    assign alarmCfgHiWr = request && we_i && sel_i[1] && wordAdr == `CAL_OFS_ALARM_CFG;

    a_value_hi_dec: assert property ((valueHiWr && s.valuePtr != 2'h0) |=> s.valuePtr == $past(s.valuePtr) - 2'h1)
        else $error("value pointer did not step down on high write");
    a_value_ptr_sat: assert property (((valueHiWr || valueRd) && s.valuePtr == 2'h0) |=> s.valuePtr == 2'h0)
        else $error("value pointer wrapped below zero");
    a_value_rd_dec: assert property ((valueRd && s.valuePtr != 2'h0) |=> s.valuePtr == $past(s.valuePtr) - 2'h1)
        else $error("value read did not step pointer");
    a_alarm_rd_dec: assert property ((alarmRd && s.alarmPtr != 2'h0) |=> s.alarmPtr == $past(s.alarmPtr) - 2'h1)
        else $error("alarm read did not step pointer");
    a_low_write_hold: assert property (valueLoOnlyWr |=> $stable(s.valuePtr))
        else $error("low byte write moved the pointer");
    a_locked_year: assert property ((valueHiWr || valueLoOnlyWr) && !s.unlock && s.valuePtr == 2'h3
        && !(s.enable && xtalEdge) |=> $stable(s.now.year))
        else $error("locked write changed the year");
    a_enable_gated: assert property ((cfgHiWr && !s.unlock) |=> $stable(s.enable))
        else $error("enable changed while locked");
    a_unlock_key: assert property ($rose(s.unlock) |-> $past(s.keyState) == KEY_OPEN && $past(cfgHiWr))
        else $error("unlock set without key sequence");
    a_half_second_status_clear: assert property ((valueLoOnlyWr && sel_i[0] && s.unlock && s.valuePtr == 2'h0)
        |=> !halfSecond && s.now.sec == $past(dat_i[7:0]))
        else $error("half second not cleared by seconds write");
    a_fields_bcd: assert property (s.now.sec[3:0] <= 4'h9 && s.now.sec <= 8'h59 && s.now.min <= 8'h59
        && s.now.hour <= 8'h23 && s.now.year[3:0] <= 4'h9)
        else $error("time field left its BCD range");
    a_unused_high_zero: assert property ((valueRd && s.valuePtr == 2'h3) |=> ack_o && dat_o[15:8] == 8'h00)
        else $error("unused high byte read nonzero");
    a_seconds_pin: assert property ((s.outEnable && s.outSelect) |=> calendarPin == !$past(halfSecond))
        else $error("pin does not follow the seconds clock");
    a_alarm_hi_dec: assert property ((alarmHiWr && s.alarmPtr != 2'h0) |=> s.alarmPtr == $past(s.alarmPtr) - 2'h1)
        else $error("alarm pointer did not step down on high write");
    a_alarm_low_hold: assert property (alarmLoOnlyWr |=> $stable(s.alarmPtr))
        else $error("alarm low byte write moved the pointer");
    a_alarm_unused_zero: assert property ((alarmRd && s.alarmPtr == 2'h3) |=> dat_o[15:0] == 16'h0000)
        else $error("unimplemented alarm pair read nonzero");
    a_value_ptr_load: assert property (cfgHiWr |=> s.valuePtr == $past(dat_i[`CAL_PTR_HI:`CAL_PTR_LO]))
        else $error("value pointer not loaded from config write");
    a_alarm_ptr_load: assert property (alarmCfgHiWr |=> s.alarmPtr == $past(dat_i[`CAL_PTR_HI:`CAL_PTR_LO]))
        else $error("alarm pointer not loaded from config write");
    a_unlock_clear: assert property ((cfgHiWr && !dat_i[`CAL_BIT_UNLOCK]) |=> !s.unlock)
        else $error("write lock did not close on request");
    a_date_range: assert property (s.now.day != 8'h00 && s.now.day <= 8'h31 && s.now.month != 8'h00
        && s.now.month <= 8'h12 && s.now.wday <= 8'h06)
        else $error("date field left its range");
    // Swallowed ticks must not advance the second; bus cycles are left out since a seconds write clears the count.
    a_swallow_hold: assert property ((s.enable && xtalEdge && s.swallow != 10'h000 && !request)
        |=> $stable(s.prescaler) && s.swallow == $past(s.swallow) - 10'h001)
        else $error("swallowed tick advanced the prescaler");
    a_pin_disabled: assert property (!s.outEnable |=> !calendarPin)
        else $error("pin active while output disabled");
    // Positive codes preload up to 508 ticks, so a crystal rate at or below that would break this.
    a_prescaler_range: assert property (s.prescaler <= LAST_TICK)
        else $error("prescaler ran past the last tick");

    c_unlock_set: cover property ($rose(s.unlock));
    c_minute_roll: cover property (s.now.sec == 8'h59 ##[1:1000] s.now.sec == 8'h00);
    c_alarm_fire: cover property ($rose(s.alarmPulse));
    c_ptr_walk: cover property (valueRd && s.valuePtr == 2'h3 ##[1:20] valueRd && s.valuePtr == 2'h0);
    c_leap_day: cover property (s.now.month == 8'h02 && s.now.day == 8'h29);

endmodule // cal_calendar_clock

// ### verilog/cal_defs.svh
`ifndef CAL_DEFS_SVH
`define CAL_DEFS_SVH

// Register byte offsets on the bus.
`define CAL_OFS_CONFIG 5'h00
`define CAL_OFS_VALUE_WIN 5'h04
`define CAL_OFS_ALARM_CFG 5'h08
`define CAL_OFS_ALARM_WIN 5'h0C
`define CAL_OFS_UNLOCK_KEY 5'h10
`define CAL_OFS_PAD_CFG 5'h14

// Field positions in the clock configuration register.
`define CAL_BIT_ENABLE 15
`define CAL_BIT_UNLOCK 13
`define CAL_BIT_SYNC 12
`define CAL_BIT_HALF_SECOND_STATUS 11
`define CAL_BIT_OUTEN 10
`define CAL_PTR_HI 9
`define CAL_PTR_LO 8
// Field positions in the alarm configuration and pad registers.
`define CAL_BIT_ALARM_EN 15
`define CAL_BIT_OUT_SELECT 1

// Unlock key sequence.
`define CAL_KEY_FIRST 8'h55
`define CAL_KEY_SECOND 8'hAA

// Crystal rate in hertz and calibration step in crystal pulses.
`define CAL_XTAL_HZ 32768
`define CAL_CAL_STEP 4

// Reset values of the calendar: 00:00:00, weekday 0, 1 January 2000.
`define CAL_RST_DAY 8'h01
`define CAL_RST_MONTH 8'h01
`define CAL_RST_YEAR 8'h00

`endif

// ### verilog/cal_pkg.sv
package cal_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_SAW_FIRST,
        KEY_OPEN
    } cal_key_e_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
    } cal_time_t;

    typedef struct packed {
        cal_time_t now;
        cal_time_t alarm;
        logic [1:0] valuePtr;
        logic [1:0] alarmPtr;
        logic [7:0] calib;
        logic enable;
        logic unlock;
        logic outEnable;
        logic outSelect;
        logic alarmEnable;
        logic alarmPulse;
        logic pinOut;
        logic xtalPrev;
        logic ack;
        logic [14:0] prescaler;
        logic [9:0] swallow;
        cal_key_e_t keyState;
        logic [15:0] rdData;
    } cal_state_t;

endpackage
